/* core/dect_defines.svh */
// Constants for the dual 8-bit compare timer.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef DECT_DEFINES_SVH
`define DECT_DEFINES_SVH

////////////////////////////////////////////////////////////////////////
// Address map: bit 5 picks the channel, bits 4:0 the register
`define DECT_ADR_MSB   7
`define DECT_CH_BIT    5
`define DECT_REG_CTRL  5'h00
`define DECT_REG_STAT  5'h04
`define DECT_REG_CNT   5'h08
`define DECT_REG_LVA   5'h0C
`define DECT_REG_LVB   5'h10

////////////////////////////////////////////////////////////////////////
// Clock source select codes
`define DECT_CKS_OFF   3'h0
`define DECT_CKS_DIV1  3'h1
`define DECT_CKS_DIV2  3'h2
`define DECT_CKS_DIV3  3'h3
`define DECT_CKS_CASC  3'h4
`define DECT_CKS_EXTR  3'h5
`define DECT_CKS_EXTF  3'h6
`define DECT_CKS_EXTB  3'h7

// Prescaler width and tap bits (divide by 8, 64, 8192)
`define DECT_PRE_W     13
`define DECT_PRE_T1    2
`define DECT_PRE_T2    5
`define DECT_PRE_T3    12

////////////////////////////////////////////////////////////////////////
// Clear source and output action codes
`define DECT_CLR_NONE  2'h0
`define DECT_CLR_A     2'h1
`define DECT_CLR_B     2'h2
`define DECT_ACT_NONE  2'h0
`define DECT_ACT_LOW   2'h1
`define DECT_ACT_HIGH  2'h2
`define DECT_ACT_TOG   2'h3

`define DECT_CNT_MAX   8'hFF
`define DECT_CNT_ZERO  8'h00
`define DECT_BYTE_MSB  7
`define DECT_SEEN_A    1
`define DECT_SEEN_B    2
`define DECT_SEEN_W    0

`endif

/* core/dect_pkg.sv */
// Types shared by the dual 8-bit compare timer.
// Assumes dect_defines.svh holds the numeric constants.
package dect_pkg;

   // Control register, LSB first: cks, clr, ie_a, ie_b, ie_w, ext
   typedef struct packed {
      logic       ext_lvl;
      logic       ext_en;
      logic       ie_w;
      logic       ie_b;
      logic       ie_a;
      logic [1:0] clr;
      logic [2:0] cks;
   } dect_ctrl_t;

   // Control and status register
   typedef struct packed {
      logic       flag_b;
      logic       flag_a;
      logic       flag_w;
      logic       conv_trigger_enable;
      logic [1:0] act_b;
      logic [1:0] act_a;
   } dect_stat_t;

   // Interrupt requests of one channel
   typedef struct packed {
      logic wrap;
      logic match_b;
      logic match_a;
   } dect_irq_t;

endpackage

/* core/dect_tick.sv */
// Count clock source select and edge detect for one channel.
// Assumes the external clock pin is synchronous to clk_i.
`include "dect_defines.svh"
module dect_tick
   import dect_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // Source
   input  wire logic [2:0]            cks_i,
   input  wire logic [`DECT_PRE_W-1:0] pre_i,
   input  wire logic                  ext_clk_i,
   // Count pulse
   output logic                       tick_o
);

   logic lvl;
   logic prev;
   logic rise;
   logic fall;

   assign lvl = (cks_i == `DECT_CKS_DIV1) ? pre_i[`DECT_PRE_T1] :
                (cks_i == `DECT_CKS_DIV2) ? pre_i[`DECT_PRE_T2] :
                (cks_i == `DECT_CKS_DIV3) ? pre_i[`DECT_PRE_T3] :
                (cks_i[2] && cks_i != `DECT_CKS_CASC) ? ext_clk_i :
                1'b0;

   // Previous level is kept across a source change on purpose, so a
   // high old level meeting a low new one counts as a falling edge
   always_ff @(posedge clk_i) begin
      if (rst_i) prev <= 1'b0;
      else       prev <= lvl;
   end

   assign rise = lvl & ~prev;
   assign fall = ~lvl & prev;

   assign tick_o = (cks_i == `DECT_CKS_EXTR) ? rise :
                   (cks_i == `DECT_CKS_EXTB) ? (rise | fall) :
                   (cks_i == `DECT_CKS_OFF ||
                    cks_i == `DECT_CKS_CASC) ? 1'b0 :
                   fall;
endmodule

/* core/dect_timer.sv */
// Dual 8-bit compare timer with cascade, Wishbone register slave.
// Assumes pins synchronous to clk_i (40 MHz) and a classic master.
`include "dect_defines.svh"
module dect_timer
   import dect_pkg::*;
(
   // Clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   // Wishbone slave
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [`DECT_ADR_MSB:0]      wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [31:0]                 wb_dat_i,
   output logic      [31:0]                 wb_dat_o,
   output logic                             wb_ack_o,
   // Pins
   input  wire logic [1:0]                  ext_clk_i,
   input  wire logic [1:0]                  ext_clear_in_i,
   output logic                             pulse_out_ch0_o,
   output logic                             pulse_out_ch1_o,
   // Interrupt controller and converter
   output dect_irq_t [1:0]                  irq_o,
   output logic                             conv_start_o
);

   ////////////////////////////////////////////////////////////////////
   // State
   dect_ctrl_t [1:0]           ctrl;
   dect_stat_t [1:0]           stat;
   logic [1:0][7:0]            cnt;
   logic [1:0][7:0]            lva;
   logic [1:0][7:0]            lvb;
   logic [1:0][2:0]            seen;
   logic [1:0]                 ext_prev;
   logic [1:0]                 pin;
   logic [`DECT_PRE_W-1:0]     pre;

   ////////////////////////////////////////////////////////////////////
   // Bus decode
   logic                       req;
   logic                       bus_wr;
   logic                       rd_take;
   logic                       ch_sel;
   logic                       map_ok;
   logic [`DECT_CH_BIT-1:0]    reg_ofs;
   logic [1:0]                 wr_ctrl;
   logic [1:0]                 wr_stat;
   logic [1:0]                 wr_cnt;
   logic [1:0]                 wr_lva;
   logic [1:0]                 wr_lvb;
   logic [1:0][31:0]           rd_word;
   logic [31:0]                next_dat;
   dect_stat_t                 wd;

   assign req     = wb_cyc_i & wb_stb_i;
   assign bus_wr  = req & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign rd_take = req & ~wb_we_i & ~wb_ack_o;
   assign ch_sel  = wb_adr_i[`DECT_CH_BIT];
   assign reg_ofs = wb_adr_i[`DECT_CH_BIT-1:0];
   assign map_ok  = (wb_adr_i[`DECT_ADR_MSB:`DECT_CH_BIT+1] == '0);
   assign wd      = dect_stat_t'(wb_dat_i[`DECT_BYTE_MSB:0]);

   ////////////////////////////////////////////////////////////////////
   // Count sources
   logic [1:0] src;
   logic [1:0] tick;
   logic       casc16;
   logic       cmcount;
   logic       both;
   logic       t16;

   assign casc16  = (ctrl[0].cks == `DECT_CKS_CASC);
   assign cmcount = (ctrl[1].cks == `DECT_CKS_CASC);
   assign both    = casc16 & cmcount;

   ////////////////////////////////////////////////////////////////////
   // Per-channel decode and count source
   logic [1:0] eq_a;
   logic [1:0] eq_b;
   logic [1:0] ma;
   logic [1:0] mb;
   logic [1:0] ext_hit;
   logic [1:0] clr_own;
   logic [1:0] clr_hit;
   logic [1:0] wrap;
   logic [1:0] cnt_ff;

   for (genvar i = 0; i < 2; i++) begin : g_ch
      logic hit;
      assign hit = req & map_ok & (ch_sel == 1'(i));
      assign wr_ctrl[i] = bus_wr & hit & (reg_ofs == `DECT_REG_CTRL);
      assign wr_stat[i] = bus_wr & hit & (reg_ofs == `DECT_REG_STAT);
      assign wr_cnt[i]  = bus_wr & hit & (reg_ofs == `DECT_REG_CNT);
      assign wr_lva[i]  = bus_wr & hit & (reg_ofs == `DECT_REG_LVA);
      assign wr_lvb[i]  = bus_wr & hit & (reg_ofs == `DECT_REG_LVB);
      assign rd_word[i] =
         (reg_ofs == `DECT_REG_CTRL) ? 32'(ctrl[i]) :
         (reg_ofs == `DECT_REG_STAT) ? 32'(stat[i]) :
         (reg_ofs == `DECT_REG_CNT)  ? 32'(cnt[i])  :
         (reg_ofs == `DECT_REG_LVA)  ? 32'(lva[i])  :
         (reg_ofs == `DECT_REG_LVB)  ? 32'(lvb[i])  : 32'h0000_0000;

      assign eq_a[i]   = (cnt[i] == lva[i]);
      assign eq_b[i]   = (cnt[i] == lvb[i]);
      assign cnt_ff[i] = (cnt[i] == `DECT_CNT_MAX);

      dect_tick u_tick (
         .clk_i     (clk_i),
         .rst_i     (rst_i),
         .cks_i     (ctrl[i].cks),
         .pre_i     (pre),
         .ext_clk_i (ext_clk_i[i]),
         .tick_o    (src[i])
      );
   end

   // Lower byte tick of the 16-bit counter
   assign t16 = casc16 & ~both & src[1];
   // Upper byte runs on the lower byte carry in 16-bit mode
   assign tick[0] = both   ? 1'b0 :
                    casc16 ? (src[1] & cnt_ff[1]) : src[0];
   assign tick[1] = both    ? 1'b0 :
                    cmcount ? ma[0] : src[1];

   ////////////////////////////////////////////////////////////////////
   // Compare matches, only on a count tick while equal
   assign ma[0] = ~wr_lva[0] & (casc16 ? (t16 & eq_a[0] & eq_a[1]) :
                                (tick[0] & eq_a[0]));
   assign mb[0] = ~wr_lvb[0] & (casc16 ? (t16 & eq_b[0] & eq_b[1]) :
                                (tick[0] & eq_b[0]));
   assign ma[1] = ~wr_lva[1] & tick[1] & eq_a[1];
   assign mb[1] = ~wr_lvb[1] & tick[1] & eq_b[1];

   ////////////////////////////////////////////////////////////////////
   // Counter clear sources
   for (genvar i = 0; i < 2; i++) begin : g_clr
      assign ext_hit[i] = ctrl[i].ext_en &
                          (ctrl[i].ext_lvl ? ext_clear_in_i[i] :
                           (ext_clear_in_i[i] & ~ext_prev[i]));
      assign clr_own[i] = ((ctrl[i].clr == `DECT_CLR_A) & ma[i]) |
                          ((ctrl[i].clr == `DECT_CLR_B) & mb[i]) |
                          ext_hit[i];
      assign wrap[i] = tick[i] & cnt_ff[i] & ~clr_hit[i] &
                       ~wr_cnt[i];
   end

   // In 16-bit mode channel 0 decides for both bytes
   assign clr_hit[0] = clr_own[0];
   assign clr_hit[1] = casc16 ? clr_own[0] : clr_own[1];

   ////////////////////////////////////////////////////////////////////
   // Next values per channel
   logic [1:0][7:0]  next_cnt;
   dect_stat_t [1:0] next_stat;
   logic [1:0][2:0]  next_seen;
   logic [1:0][1:0]  act;
   logic [1:0]       next_pin;
   logic [1:0]       out_en;

   for (genvar i = 0; i < 2; i++) begin : g_next
      logic [1:0] act_a_eff;
      logic [1:0] act_b_eff;
      logic       clr_a;
      logic       clr_b;
      logic       clr_w;

      // Clear beats write, write beats increment
      assign next_cnt[i] = clr_hit[i] ? `DECT_CNT_ZERO :
                           wr_cnt[i]  ? wb_dat_i[`DECT_BYTE_MSB:0] :
                           tick[i]    ? cnt[i] + 8'h01 : cnt[i];

      // Write of 0 clears only after the flag was read as 1
      assign clr_a = wr_stat[i] & ~wd.flag_a & seen[i][`DECT_SEEN_A];
      assign clr_b = wr_stat[i] & ~wd.flag_b & seen[i][`DECT_SEEN_B];
      assign clr_w = wr_stat[i] & ~wd.flag_w & seen[i][`DECT_SEEN_W];

      // Hardware set wins over a software clear in the same cycle
      always_comb begin
         next_stat[i]        = stat[i];
         next_stat[i].flag_a = ma[i] | (stat[i].flag_a & ~clr_a);
         next_stat[i].flag_b = mb[i] | (stat[i].flag_b & ~clr_b);
         next_stat[i].flag_w = wrap[i] | (stat[i].flag_w & ~clr_w);
         if (wr_stat[i]) begin
            next_stat[i].act_a = wd.act_a;
            next_stat[i].act_b = wd.act_b;
            // Only channel 0 can trigger the converter
            next_stat[i].conv_trigger_enable  = (i == 0) ? wd.conv_trigger_enable : 1'b0;
         end
      end

      assign next_seen[i] = wr_stat[i] ? 3'h0 :
         (rd_take & map_ok & (ch_sel == 1'(i)) &
          (reg_ofs == `DECT_REG_STAT)) ?
            (seen[i] | {stat[i].flag_b, stat[i].flag_a, stat[i].flag_w}) :
            seen[i];

      // Higher code is higher priority: toggle, one, zero, none
      assign act_a_eff = ma[i] ? stat[i].act_a : `DECT_ACT_NONE;
      assign act_b_eff = mb[i] ? stat[i].act_b : `DECT_ACT_NONE;
      assign act[i] = (act_a_eff > act_b_eff) ? act_a_eff : act_b_eff;
      assign out_en[i] = |{stat[i].act_b, stat[i].act_a};
      assign next_pin[i] =
         ~out_en[i]                  ? 1'b0 :
         (act[i] == `DECT_ACT_TOG)  ? ~pin[i] :
         (act[i] == `DECT_ACT_HIGH) ? 1'b1 :
         (act[i] == `DECT_ACT_LOW)  ? 1'b0 : pin[i];

      assign irq_o[i].match_a = stat[i].flag_a & ctrl[i].ie_a;
      assign irq_o[i].match_b = stat[i].flag_b & ctrl[i].ie_b;
      assign irq_o[i].wrap    = stat[i].flag_w & ctrl[i].ie_w;
   end

   assign next_dat = ~map_ok ? 32'h0000_0000 : rd_word[ch_sel];

   ////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         pre      <= '0;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         if (rd_take) wb_dat_o <= next_dat;
         pre      <= pre + 1'b1;
      end
   end

   for (genvar i = 0; i < 2; i++) begin : g_reg
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            ctrl[i]     <= '0;
            stat[i]     <= '0;
            cnt[i]      <= `DECT_CNT_ZERO;
            lva[i]      <= `DECT_CNT_MAX;
            lvb[i]      <= `DECT_CNT_MAX;
            seen[i]     <= 3'h0;
            ext_prev[i] <= 1'b0;
            pin[i]      <= 1'b0;
         end else begin
            if (wr_ctrl[i]) ctrl[i] <= dect_ctrl_t'(
               wb_dat_i[$bits(dect_ctrl_t)-1:0]);
            if (wr_lva[i]) lva[i] <= wb_dat_i[`DECT_BYTE_MSB:0];
            if (wr_lvb[i]) lvb[i] <= wb_dat_i[`DECT_BYTE_MSB:0];
            stat[i]     <= next_stat[i];
            cnt[i]      <= next_cnt[i];
            seen[i]     <= next_seen[i];
            ext_prev[i] <= ext_clear_in_i[i];
            pin[i]      <= next_pin[i];
         end
      end
   end

   // Converter request comes from channel 0 match A alone
   always_ff @(posedge clk_i) begin
      if (rst_i) conv_start_o <= 1'b0;
      else       conv_start_o <= ma[0] & stat[0].conv_trigger_enable;
   end

   assign pulse_out_ch0_o = pin[0];
   assign pulse_out_ch1_o = pin[1];

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_flag_a0;
      ##1 stat[0].flag_a;
   endsequence
   sequence s_cnt0_zero;
      ##1 (cnt[0] == `DECT_CNT_ZERO);
   endsequence

   property p_match_flag;
      ma[0] |-> s_flag_a0;
   endproperty
   a_match_flag: assert property (p_match_flag)
      else $error("match A did not set its flag");

   property p_clear_a;
      (ma[0] && ctrl[0].clr == `DECT_CLR_A) |-> s_cnt0_zero;
   endproperty
   a_clear_a: assert property (p_clear_a)
      else $error("counter not cleared on match A");

   property p_wrap;
      (tick[1] && cnt_ff[1] && !clr_hit[1] && !wr_cnt[1])
         |=> stat[1].flag_w && cnt[1] == `DECT_CNT_ZERO;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("wrap flag missing after FF to 00");

   property p_conv;
      conv_start_o |-> $past(ma[0]) && $past(stat[0].conv_trigger_enable);
   endproperty
   a_conv: assert property (p_conv)
      else $error("conversion request without channel 0 match A");

   property p_write_wins;
      (wr_cnt[1] && !clr_hit[1])
         |=> cnt[1] == $past(wb_dat_i[`DECT_BYTE_MSB:0]);
   endproperty
   a_write_wins: assert property (p_write_wins)
      else $error("counter write lost to increment");

   property p_clear_wins;
      (clr_hit[0] && wr_cnt[0]) |=> cnt[0] == `DECT_CNT_ZERO;
   endproperty
   a_clear_wins: assert property (p_clear_wins)
      else $error("counter write beat a clear");

   property p_lvl_write;
      (wr_lva[0] && !stat[0].flag_a) |=> !stat[0].flag_a;
   endproperty
   a_lvl_write: assert property (p_lvl_write)
      else $error("match flag set during level write");

   property p_toggle;
      (ma[1] && stat[1].act_a == `DECT_ACT_TOG)
         |=> pulse_out_ch1_o != $past(pulse_out_ch1_o);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("toggle action did not invert the pin");

   property p_no_set;
      (wr_stat[0] && !stat[0].flag_w && !wrap[0]) |=> !stat[0].flag_w;
   endproperty
   a_no_set: assert property (p_no_set)
      else $error("software set a wrap flag");

   property p_stop;
      both |-> ##1 $stable(cnt[0]) || $past(clr_hit[0] || wr_cnt[0]);
   endproperty
   a_stop: assert property (p_stop)
      else $error("counter moved with both cascade modes set");

   property p_disabled;
      !out_en[0] |=> !pulse_out_ch0_o;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("pin driven while output disabled");
endmodule

/* test/dect_pins_model.sv */
// Pin-side partner of the compare timer: external clocks, clears, A/D.
// Assumes it is driven from the bench's 40 MHz clock, rising edge.
module dect_pins_model
   import dect_pkg::*;
(
   // Clock
   input  wire logic       clk_i,
   // Converter start request
   input  wire logic       conv_start_i,
   // Pins towards the timer
   output logic      [1:0] ext_clk_o,
   output logic      [1:0] ext_clear_o
);
   timeunit 1ns;
   timeprecision 1ps;

   int conv_count;

   initial begin
      ext_clk_o   = 2'h0;
      ext_clear_o = 2'h0;
      conv_count  = 0;
   end

   ////////////////////////////////////////////////////////////////////
   // Converter side counts start pulses
   always @(posedge clk_i) begin
      if (conv_start_i === 1'b1)
         conv_count <= conv_count + 1;
   end

   ////////////////////////////////////////////////////////////////////
   // Pulses are 3 states high and 4 low, well inside the minimum
   task automatic clk_pulse(input int ch, input int n);
      repeat (n) begin
         @(posedge clk_i);
         ext_clk_o[ch] <= 1'b1;
         repeat (3) @(posedge clk_i);
         ext_clk_o[ch] <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
   endtask

   task automatic clear_pulse(input int ch);
      @(posedge clk_i);
      ext_clear_o[ch] <= 1'b1;
      repeat (3) @(posedge clk_i);
      ext_clear_o[ch] <= 1'b0;
      @(posedge clk_i);
   endtask
endmodule

/* test/dect_timer_bench.sv */
// Self-checking bench for the dual 8-bit compare timer.
// Assumes dect_pins_model as far side and a 40 MHz clk_i.
`include "dect_defines.svh"
module dect_timer_bench
   import dect_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic             clk_i;
   logic             rst_i;
   logic             wb_cyc_i;
   logic             wb_stb_i;
   logic             wb_we_i;
   logic [7:0]       wb_adr_i;
   logic [3:0]       wb_sel_i;
   logic [31:0]      wb_dat_i;
   logic [31:0]      wb_dat_o;
   logic             wb_ack_o;
   logic [1:0]       ext_clk_i;
   logic [1:0]       ext_clear_in_i;
   logic             pulse_out_ch0_o;
   logic             pulse_out_ch1_o;
   dect_irq_t [1:0]  irq_o;
   logic             conv_start_o;
   int               mismatches;
   int               tests_run;
   logic [31:0]      clr_mode [2];

   dect_timer u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk_i),
      .ext_clear_in_i(ext_clear_in_i), .pulse_out_ch0_o(pulse_out_ch0_o),
      .pulse_out_ch1_o(pulse_out_ch1_o), .irq_o(irq_o),
      .conv_start_o(conv_start_o));

   dect_pins_model u_pins (
      .clk_i(clk_i), .conv_start_i(conv_start_o),
      .ext_clk_o(ext_clk_i), .ext_clear_o(ext_clear_in_i));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////
   // Checks and verdict
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic chk_bits(input logic [2:0] got, input logic [2:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: bits %b, wanted %b", $time, got, exp);
      end
   endtask

   task automatic results();
      if (mismatches == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // Classic Wishbone cycle; entered just after a rising edge
   task automatic wb_cycle(input logic [7:0] adr, input logic we,
                           input logic [31:0] dat, output logic [31:0] rd);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'hF;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         $display("unexpected at %0t: no bus answer", $time);
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] rd;
      wb_cycle(adr, 1'b1, dat, rd);
   endtask

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      wb_cycle(adr, 1'b0, 32'h0, rd);
      chk_word(rd, exp);
   endtask

   task automatic settle();
      repeat (4) @(posedge clk_i);
   endtask

   ////////////////////////////////////////////////////////////////////
   // Watchdog: the run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      $display("unexpected at %0t: run timed out", $time);
      results();
   end

   initial begin
      rst_i    = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i  = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      mismatches = 0;
      tests_run  = 0;
      clr_mode[0] = 32'h305;
      clr_mode[1] = 32'h105;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // Reset state, unmapped slot reads zero
      rd_chk({3'h0, `DECT_REG_CTRL}, 32'h0);
      rd_chk({3'h0, `DECT_REG_LVA}, 32'hFF);
      rd_chk(8'h14, 32'h0);
      chk_bits({1'b0, pulse_out_ch1_o, pulse_out_ch0_o}, 3'h0);
      // Ch0: B at 1 drives low, A at 2 toggles and clears
      wr({3'h0, `DECT_REG_LVA}, 32'h2);
      wr({3'h0, `DECT_REG_LVB}, 32'h1);
      wr({3'h0, `DECT_REG_STAT}, 32'h17);
      wr({3'h0, `DECT_REG_CTRL}, 32'h6D);
      u_pins.clk_pulse(0, 3);
      settle();
      rd_chk({3'h0, `DECT_REG_CNT}, 32'h0);
      chk_bits({2'h0, pulse_out_ch0_o}, 3'h1);
      chk_bits(irq_o[0], 3'h3);
      chk_word(32'(u_pins.conv_count), 32'h1);
      rd_chk({3'h0, `DECT_REG_STAT}, 32'hD7);
      // Flags clear by writing 0, never set by writing 1
      wr({3'h0, `DECT_REG_STAT}, 32'h17);
      chk_bits(irq_o[0], 3'h0);
      wr({3'h0, `DECT_REG_STAT}, 32'hD7);
      rd_chk({3'h0, `DECT_REG_STAT}, 32'h17);
      u_pins.clk_pulse(0, 2);
      settle();
      chk_bits({2'h0, pulse_out_ch0_o}, 3'h0);
      rd_chk({3'h0, `DECT_REG_CNT}, 32'h2);
      u_pins.clk_pulse(0, 1);
      settle();
      chk_bits({2'h0, pulse_out_ch0_o}, 3'h1);
      // Ch1 wraps from FF with only the wrap interrupt enabled
      wr({3'h1, `DECT_REG_CTRL}, 32'h85);
      wr({3'h1, `DECT_REG_CNT}, 32'hFE);
      u_pins.clk_pulse(1, 2);
      settle();
      rd_chk({3'h1, `DECT_REG_CNT}, 32'h0);
      rd_chk({3'h1, `DECT_REG_STAT}, 32'hE0);
      chk_bits(irq_o[1], 3'h4);
      chk_bits({2'h0, pulse_out_ch1_o}, 3'h0);
      chk_word(32'(u_pins.conv_count), 32'h2);
      // External clear, level then edge
      foreach (clr_mode[i]) begin
         wr({3'h0, `DECT_REG_CTRL}, clr_mode[i]);
         wr({3'h0, `DECT_REG_CNT}, 32'h40);
         u_pins.clear_pulse(0);
         settle();
         rd_chk({3'h0, `DECT_REG_CNT}, 32'h0);
      end
      // Ch1 counts ch0 match A events
      wr({3'h0, `DECT_REG_CTRL}, 32'h0D);
      wr({3'h1, `DECT_REG_CTRL}, 32'h4);
      wr({3'h1, `DECT_REG_CNT}, 32'h0);
      u_pins.clk_pulse(0, 6);
      settle();
      rd_chk({3'h1, `DECT_REG_CNT}, 32'h2);
      chk_word(32'(u_pins.conv_count), 32'h4);
      // 16-bit mode, ch1 clear on B must be ignored
      wr({3'h1, `DECT_REG_CTRL}, 32'h15);
      wr({3'h0, `DECT_REG_CTRL}, 32'h0C);
      wr({3'h0, `DECT_REG_CNT}, 32'h0);
      wr({3'h1, `DECT_REG_CNT}, 32'h0);
      wr({3'h0, `DECT_REG_LVA}, 32'h0);
      wr({3'h1, `DECT_REG_LVA}, 32'h3);
      wr({3'h1, `DECT_REG_LVB}, 32'h1);
      u_pins.clk_pulse(1, 3);
      settle();
      rd_chk({3'h1, `DECT_REG_CNT}, 32'h3);
      rd_chk({3'h0, `DECT_REG_CNT}, 32'h0);
      u_pins.clk_pulse(1, 1);
      settle();
      rd_chk({3'h1, `DECT_REG_CNT}, 32'h0);
      chk_bits({2'h0, pulse_out_ch0_o}, 3'h0);
      chk_word(32'(u_pins.conv_count), 32'h5);
      results();
   end
endmodule
